// ### include/atic_pkg.sv
// Package for the light threshold interrupt and configuration register bank
package atic_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_LOW_THRESHOLD_LSB = 8'h84;
  localparam logic [7:0] ADDR_LOW_THRESHOLD_MSB = 8'h85;
  localparam logic [7:0] ADDR_HIGH_THRESHOLD_LSB = 8'h86;
  localparam logic [7:0] ADDR_HIGH_THRESHOLD_MSB = 8'h87;
  localparam logic [7:0] ADDR_PERSISTENCE_FILTER = 8'h8c;
  localparam logic [7:0] ADDR_CONFIG_ZERO_WAIT = 8'h8d;
  localparam logic [7:0] ADDR_CONFIG_ONE_GAIN = 8'h90;
  localparam logic [7:0] ADDR_REVISION_NUMBER = 8'h91;
  localparam logic [7:0] ADDR_STATUS = 8'h93;
  // Field positions
  localparam int LONG_WAIT_BIT = 2;
  localparam int LIGHT_INT_FLAG_BIT = 4;
  // Reset values
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_PERSISTENCE = 8'h00;
  localparam logic [7:0] RST_CONFIG_ZERO = 8'h80;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  // Reserved upper bits of the revision register
  localparam logic [4:0] REVISION_UPPER = 5'h0c;
  // Timing: one wait step in microseconds and the long wait factor
  localparam int WAIT_STEP_US = 2800;
  localparam int CLK_MHZ = 40;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
  localparam int LONG_WAIT_FACTOR = 12;

  // Register write and read strobes with address and write data
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } atic_bus_t;

  // Gain selections, one-hot
  typedef enum logic [3:0] {
    GAIN_1X = 4'h1,
    GAIN_4X = 4'h2,
    GAIN_16X = 4'h4,
    GAIN_64X = 4'h8
  } atic_gain_t;
endpackage : atic_pkg

// ### design/atic_top.sv
// Light threshold compare, persistence filter, wait timer and config registers
// Behaviour
// - Each visible result is compared with a 16-bit low threshold made of two bytes.
// - A result below the low threshold with persistence met sets the light interrupt flag.
// - A result above the high threshold with persistence met sets the light interrupt flag.
// - With the light interrupt enable set, the interrupt pin asserts while the flag is set.
// - A threshold low byte is buffered and both bytes load together on the high byte write.
// - Code 0 fires always, 1 on any outlier, 2-7 and 13-15 need 2,3,5,10,15,20,50,55,60 outliers.
// - Consecutive out-of-range results are counted and fire when the count equals the setting.
// - An in-range result clears the persistence counter.
// - The long wait bit, bit 2 of config zero, multiplies the wait period by twelve.
// - The wait timer is a down counter lasting value plus one steps of 2.8ms.
// - Gain field bits 1:0 of config one decode to 1x, 4x, 16x and 64x.
// - Writing a one to a status flag bit clears that flag.
`timescale 1ns/100ps
module atic_top #(
  parameter int STEP_CYCLES = atic_pkg::WAIT_STEP_CYCLES,
  parameter logic [2:0] REVISION_CODE = 3'h5 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register access
  input wire atic_pkg::atic_bus_t regBus,
  output logic [7:0] rdData,
  // Measurement and control inputs
  input wire logic [15:0] visResult,
  input wire logic visValid,
  input wire logic lightIntEnable,
  input wire logic [7:0] waitPeriodValue,
  input wire logic waitStart,
  // Outputs
  output logic intPinOut,
  output logic intPinOe,
  output logic waitDone,
  output logic lightIntFlag,
  output atic_pkg::atic_gain_t gainSelect
);

  // Whole module state in one struct
  typedef struct packed {
    // Raw threshold bytes as written, read back as they stand
    logic [7:0] lowLsb;
    logic [7:0] lowMsb;
    logic [7:0] highLsb;
    logic [7:0] highMsb;
    // Active limits, loaded only by a high byte write
    logic [15:0] lowThr;
    logic [15:0] highThr;
    // Configuration bytes kept whole, reserved bits included
    logic [7:0] persistence_filter;
    logic [7:0] config_zero_wait;
    logic [7:0] config_one_gain;
    // Persistence run length and the interrupt flag
    logic [5:0] persCnt;
    logic flag;
    // Registered outputs
    logic [7:0] rd;
    logic pinOut;
    logic pinOe;
    // Wait timer: long repeats, steps left and clocks within a step
    logic [3:0] longCnt;
    logic [8:0] stepsLeft;
    logic [31:0] tickCnt;
    logic waitBusy;
    logic done;
    atic_pkg::atic_gain_t gain;
  } atic_state_t;

  atic_state_t state_r;
  atic_state_t state_nxt;

  // Persistence code to required consecutive count
  function automatic logic [5:0] persNeed(input logic [3:0] code);
    case (code)
      4'h0: persNeed = 6'h00;
      4'h1: persNeed = 6'h01;
      4'h2: persNeed = 6'h02;
      4'h3: persNeed = 6'h03;
      4'h4: persNeed = 6'h05;
      4'h5: persNeed = 6'h0a;
      4'h6: persNeed = 6'h0f;
      4'h7: persNeed = 6'h14;
      4'h8: persNeed = 6'h19;
      4'h9: persNeed = 6'h1e;
      4'ha: persNeed = 6'h23;
      4'hb: persNeed = 6'h28;
      4'hc: persNeed = 6'h2d;
      4'hd: persNeed = 6'h32;
      4'he: persNeed = 6'h37;
      default: persNeed = 6'h3c;
    endcase
  endfunction : persNeed

  function automatic atic_pkg::atic_gain_t gainDecode(input logic [1:0] code);
    case (code)
      2'h0: gainDecode = atic_pkg::GAIN_1X;
      2'h1: gainDecode = atic_pkg::GAIN_4X;
      2'h2: gainDecode = atic_pkg::GAIN_16X;
      default: gainDecode = atic_pkg::GAIN_64X;
    endcase
  endfunction : gainDecode

  // Helpers, each given a value in the process before its first use
  logic wrHit;
  logic outOfRange;
  logic [5:0] need;
  logic [5:0] cntNext;
  logic fire;
  logic clearFlag;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    wrHit = regBus.wrEn;
    // Strict compares: a result equal to a limit is in range
    // low and high compare
    outOfRange = (visResult < state_r.lowThr) || (visResult > state_r.highThr);
    // Code 0 bypasses the counter and fires on every result
    // persistence decode
    need = persNeed(state_r.persistence_filter[3:0]);
    cntNext = state_r.persCnt;
    fire = 1'b0;
    if (visValid)
    begin
      if (need == 6'h00)
      begin
        fire = 1'b1;
        cntNext = 6'h00;
      end
      else if (outOfRange)
      begin
        // Saturate so a very long run can never wrap and fire again
        // count and compare
        cntNext = (state_r.persCnt == 6'h3f) ? state_r.persCnt : state_r.persCnt + 6'h01;
        fire = (cntNext == need);
      end
      else
      begin
        cntNext = 6'h00;
      end
    end
    state_nxt.persCnt = cntNext;

    // Register writes
    clearFlag = 1'b0;
    if (wrHit)
    begin
      case (regBus.addr)
        atic_pkg::ADDR_LOW_THRESHOLD_LSB: state_nxt.lowLsb = regBus.wrData;
        atic_pkg::ADDR_LOW_THRESHOLD_MSB:
        begin
          state_nxt.lowMsb = regBus.wrData;
          // relies on low then high order
          state_nxt.lowThr = {regBus.wrData, state_r.lowLsb};
        end
        atic_pkg::ADDR_HIGH_THRESHOLD_LSB: state_nxt.highLsb = regBus.wrData;
        atic_pkg::ADDR_HIGH_THRESHOLD_MSB:
        begin
          state_nxt.highMsb = regBus.wrData;
          state_nxt.highThr = {regBus.wrData, state_r.highLsb};
        end
        atic_pkg::ADDR_PERSISTENCE_FILTER: state_nxt.persistence_filter = regBus.wrData;
        // stored as written, host keeps reserved bits
        atic_pkg::ADDR_CONFIG_ZERO_WAIT: state_nxt.config_zero_wait = regBus.wrData;
        atic_pkg::ADDR_CONFIG_ONE_GAIN: state_nxt.config_one_gain = regBus.wrData;
        atic_pkg::ADDR_STATUS: clearFlag = regBus.wrData[atic_pkg::LIGHT_INT_FLAG_BIT];
        // Revision and unmapped writes are dropped
        default: ;
      endcase
    end

    // A result firing in the clear cycle must not be lost
    // set flag; set wins over clear
    if (fire)
    begin
      state_nxt.flag = 1'b1;
    end
    else if (clearFlag)
    begin
      state_nxt.flag = 1'b0;
    end

    // Enable is taken with the flag, so the pin drops in the clear cycle
    // open-drain pin, active low, driven while flag and enable
    state_nxt.pinOut = 1'b0;
    state_nxt.pinOe = state_nxt.flag && lightIntEnable;

    // Decoded from the next value so gain moves with the write
    // gain decode
    state_nxt.gain = gainDecode(state_nxt.config_one_gain[1:0]);

    // Reads of unmapped addresses return zero
    // Read mux, registered one cycle after the read strobe
    if (regBus.rdEn)
    begin
      case (regBus.addr)
        atic_pkg::ADDR_LOW_THRESHOLD_LSB: state_nxt.rd = state_r.lowLsb;
        atic_pkg::ADDR_LOW_THRESHOLD_MSB: state_nxt.rd = state_r.lowMsb;
        atic_pkg::ADDR_HIGH_THRESHOLD_LSB: state_nxt.rd = state_r.highLsb;
        atic_pkg::ADDR_HIGH_THRESHOLD_MSB: state_nxt.rd = state_r.highMsb;
        atic_pkg::ADDR_PERSISTENCE_FILTER: state_nxt.rd = state_r.persistence_filter;
        atic_pkg::ADDR_CONFIG_ZERO_WAIT: state_nxt.rd = state_r.config_zero_wait;
        atic_pkg::ADDR_CONFIG_ONE_GAIN: state_nxt.rd = state_r.config_one_gain;
        atic_pkg::ADDR_REVISION_NUMBER: state_nxt.rd = {atic_pkg::REVISION_UPPER, REVISION_CODE};
        atic_pkg::ADDR_STATUS:
          state_nxt.rd = 8'(32'(state_r.flag) << atic_pkg::LIGHT_INT_FLAG_BIT);
        default: state_nxt.rd = 8'h00;
      endcase
    end

    // A start while busy is ignored, so a stray pulse cannot stretch a wait
    // The long bit is read again at each step; changing it mid-wait is legal
    // down counter of step ticks, value plus one steps
    // long wait repeats each step twelve times
    state_nxt.done = 1'b0;
    if (waitStart && !state_r.waitBusy)
    begin
      state_nxt.waitBusy = 1'b1;
      state_nxt.stepsLeft = {1'b0, waitPeriodValue};
      state_nxt.tickCnt = 32'(STEP_CYCLES - 1);
      state_nxt.longCnt = state_r.config_zero_wait[atic_pkg::LONG_WAIT_BIT] ?
        4'(atic_pkg::LONG_WAIT_FACTOR - 1) : 4'h0;
    end
    else if (state_r.waitBusy)
    begin
      if (state_r.tickCnt != 32'h0)
      begin
        state_nxt.tickCnt = state_r.tickCnt - 32'h1;
      end
      else
      begin
        // One sub-period ends here; a long step is twelve of them
        state_nxt.tickCnt = 32'(STEP_CYCLES - 1);
        if (state_r.longCnt != 4'h0)
        begin
          state_nxt.longCnt = state_r.longCnt - 4'h1;
        end
        else if (state_r.stepsLeft != 9'h0)
        begin
          state_nxt.stepsLeft = state_r.stepsLeft - 9'h1;
          state_nxt.longCnt = state_r.config_zero_wait[atic_pkg::LONG_WAIT_BIT] ?
            4'(atic_pkg::LONG_WAIT_FACTOR - 1) : 4'h0;
        end
        else
        begin
          state_nxt.waitBusy = 1'b0;
          state_nxt.done = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      // Constants only; counters, flag and outputs start at zero, except gain at GAIN_1X
      state_r <= '0;
      state_r.persistence_filter <= atic_pkg::RST_PERSISTENCE;
      state_r.config_zero_wait <= atic_pkg::RST_CONFIG_ZERO;
      state_r.config_one_gain <= atic_pkg::RST_CONFIG_ONE;
      state_r.lowLsb <= atic_pkg::RST_THRESHOLD;
      state_r.lowMsb <= atic_pkg::RST_THRESHOLD;
      state_r.highLsb <= atic_pkg::RST_THRESHOLD;
      state_r.highMsb <= atic_pkg::RST_THRESHOLD;
      // Active limits match their bytes, so no latch is needed first
      state_r.lowThr <= {atic_pkg::RST_THRESHOLD, atic_pkg::RST_THRESHOLD};
      state_r.highThr <= {atic_pkg::RST_THRESHOLD, atic_pkg::RST_THRESHOLD};
      state_r.gain <= atic_pkg::GAIN_1X;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Pin data stays low; only its enable moves
  // Outputs straight from flops
  assign rdData = state_r.rd;
  assign intPinOut = state_r.pinOut;
  assign intPinOe = state_r.pinOe;
  assign waitDone = state_r.done;
  assign lightIntFlag = state_r.flag;
  assign gainSelect = state_r.gain;

endmodule : atic_top

// ### dv/atic_host.sv
// Host model driving the register strobes
`timescale 1ns/100ps
module atic_host (
  // Clock
  input wire logic clk_sys,
  // Register strobes
  output atic_pkg::atic_bus_t regBus
);
  initial regBus = '0;
  // One strobe cycle, changed just after the edge
  task automatic xfer(input logic w, r, input logic [7:0] a, d);
    regBus = {w, r, a, d};
    @(posedge clk_sys);
    #1;
  endtask : xfer
  task automatic idle();
    regBus = '0;
    @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic wrThr(input logic [7:0] a, input logic [15:0] v);
    xfer(1'b1, 1'b0, a, v[7:0]);
    xfer(1'b1, 1'b0, a + 8'h01, v[15:8]);
    idle();
  endtask : wrThr
  task automatic wrCfg0(input logic lw);
    xfer(1'b1, 1'b0, atic_pkg::ADDR_CONFIG_ZERO_WAIT, {5'h10, lw, 2'h0});
    idle();
  endtask : wrCfg0
  // write one to clear the flag
  task automatic clrFlag();
    xfer(1'b1, 1'b0, atic_pkg::ADDR_STATUS, 8'h10);
    idle();
  endtask : clrFlag
endmodule : atic_host

// ### dv/atic_top_asserts.sv
// Port checker for the threshold interrupt bank
`timescale 1ns/100ps
module atic_checker #(
  parameter logic [2:0] REVISION_CODE = 3'h5
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Inputs
  input wire atic_pkg::atic_bus_t regBus,
  input wire logic visValid,
  input wire logic lightIntEnable,
  // Outputs
  input wire logic [7:0] rdData,
  input wire logic intPinOut,
  input wire logic intPinOe,
  input wire logic waitDone,
  input wire logic lightIntFlag,
  input wire atic_pkg::atic_gain_t gainSelect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Status write with the flag bit set
  sequence s_clr;
    regBus.wrEn && regBus.addr == atic_pkg::ADDR_STATUS && regBus.wrData[4];
  endsequence
  sequence s_revRd;
    regBus.rdEn && regBus.addr == atic_pkg::ADDR_REVISION_NUMBER;
  endsequence
  a_pin_follows: assert property (intPinOe == (lightIntFlag && $past(lightIntEnable)))
    else $error("pin not pulled");
  a_pin_quiet: assert property (!lightIntFlag |-> !intPinOe && !intPinOut)
    else $error("pin pulled without flag");
  a_flag_clear: assert property (s_clr ##0 !visValid |=> !lightIntFlag)
    else $error("flag not cleared");
  a_flag_cause: assert property ($rose(lightIntFlag) |-> $past(visValid))
    else $error("flag set without result");
  a_flag_holds: assert property (lightIntFlag && !regBus.wrEn |=> lightIntFlag)
    else $error("flag dropped");
  a_gain_write: assert property (regBus.wrEn && regBus.addr == 8'h90
    |=> gainSelect == 4'h1 << $past(regBus.wrData[1:0])) else $error("gain wrong");
  a_done_pulse: assert property (waitDone |=> !waitDone)
    else $error("done too long");
  a_rev_read: assert property (s_revRd |=> rdData[2:0] == REVISION_CODE)
    else $error("revision wrong");
endmodule : atic_checker
bind atic_top atic_checker #(.REVISION_CODE(REVISION_CODE)) atic_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .regBus(regBus), .visValid(visValid),
  .lightIntEnable(lightIntEnable), .rdData(rdData), .intPinOut(intPinOut),
  .intPinOe(intPinOe), .waitDone(waitDone), .lightIntFlag(lightIntFlag),
  .gainSelect(gainSelect));

// ### dv/test_atic_top.sv
// Self-checking bench for the threshold interrupt bank
`timescale 1ns/100ps
module test_atic_top;
  localparam int STEP = 4;
  logic clk_sys = 0;
  logic nrst = 0;
  atic_pkg::atic_bus_t regBus;
  logic [7:0] rdData;
  logic [7:0] waitPeriodValue = 0;
  logic [15:0] visResult = 0;
  logic visValid = 0;
  logic lightIntEnable = 0;
  logic waitStart = 0;
  logic intPinOut, intPinOe, waitDone, lightIntFlag, rdLag;
  atic_pkg::atic_gain_t gainSelect;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] expQ[$];
  logic [7:0] ra[9] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h8c, 8'h8d, 8'h90, 8'h91, 8'h99};
  logic [7:0] rv[9] = '{0, 0, 0, 0, 0, 8'h80, 0, {atic_pkg::REVISION_UPPER, 3'h5}, 0};
  int persistence_filter[16] = '{1, 1, 2, 3, 5, 10, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60};
  atic_top #(.STEP_CYCLES(STEP), .REVISION_CODE(3'h5)) atic_top_inst (.clk_sys(clk_sys),
    .nrst(nrst), .regBus(regBus), .rdData(rdData), .visResult(visResult),
    .visValid(visValid), .lightIntEnable(lightIntEnable), .waitPeriodValue(waitPeriodValue),
    .waitStart(waitStart), .intPinOut(intPinOut), .intPinOe(intPinOe), .waitDone(waitDone),
    .lightIntFlag(lightIntFlag), .gainSelect(gainSelect));
  atic_host atic_host_inst (.clk_sys(clk_sys), .regBus(regBus));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, e);
    expQ.push_back(e);
    atic_host_inst.xfer(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  // Hold a result for n cycles, then one idle cycle
  task automatic send(input logic [15:0] v, input int n);
    visResult = v;
    visValid = 1;
    repeat (n) @(posedge clk_sys);
    #1;
    visValid = 0;
    @(posedge clk_sys);
    #1;
  endtask : send
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Read data lands one cycle after the strobe
  always @(posedge clk_sys) rdLag <= regBus.rdEn;
  always @(negedge clk_sys)
    if (rdLag === 1'b1)
      chk("rdData", rdData, expQ.pop_front());
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial
  begin
    logic [15:0] r;
    int n;
    void'($urandom(32'h9a27));
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1;
    chk("gain", gainSelect, atic_pkg::GAIN_1X);
    atic_host_inst.xfer(1'b1, 1'b0, atic_pkg::ADDR_REVISION_NUMBER, 8'hff);
    for (int i = 0; i < 9; i++)
      rd(ra[i], rv[i]);
    for (int i = 0; i < 4; i++)
    begin
      atic_host_inst.xfer(1'b1, 1'b0, atic_pkg::ADDR_CONFIG_ONE_GAIN, 8'(i));
      atic_host_inst.idle();
      chk("gain", gainSelect, 4'h1 << i);
    end
    lightIntEnable = 1;
    atic_host_inst.wrThr(atic_pkg::ADDR_HIGH_THRESHOLD_LSB, 16'hffff);
    atic_host_inst.xfer(1'b1, 1'b0, atic_pkg::ADDR_PERSISTENCE_FILTER, 8'h01);
    atic_host_inst.xfer(1'b1, 1'b0, atic_pkg::ADDR_LOW_THRESHOLD_LSB, 8'h10);
    rd(atic_pkg::ADDR_LOW_THRESHOLD_LSB, 8'h10);
    atic_host_inst.idle();
    send(16'h0005, 1);
    chk("flag", lightIntFlag, 0);
    atic_host_inst.wrThr(atic_pkg::ADDR_LOW_THRESHOLD_LSB, 16'h0010);
    send(16'h0005, 1);
    chk("flag", lightIntFlag, 1);
    chk("pin", intPinOe, 1);
    chk("pinOut", intPinOut, 0);
    atic_host_inst.clrFlag();
    chk("flag", lightIntFlag, 0);
    r = 16'h0100 + 16'($urandom_range(16'hfe00));
    atic_host_inst.wrThr(atic_pkg::ADDR_LOW_THRESHOLD_LSB, 16'h0000);
    atic_host_inst.wrThr(atic_pkg::ADDR_HIGH_THRESHOLD_LSB, r);
    send(r, 1);
    chk("flag", lightIntFlag, 0);
    send(r + 16'h1, 1);
    chk("flag", lightIntFlag, 1);
    atic_host_inst.clrFlag();
    atic_host_inst.wrThr(atic_pkg::ADDR_LOW_THRESHOLD_LSB, 16'h1000);
    atic_host_inst.wrThr(atic_pkg::ADDR_HIGH_THRESHOLD_LSB, 16'h2000);
    for (int c = 0; c < 16; c++)
    begin
      lightIntEnable = 1'($urandom);
      atic_host_inst.xfer(1'b1, 1'b0, atic_pkg::ADDR_PERSISTENCE_FILTER, 8'(c));
      atic_host_inst.idle();
      if (persistence_filter[c] > 1)
      begin
        // In-range result empties the run left by the last code
        send(16'h1800, 1);
        send(16'h3000, persistence_filter[c] - 1);
        send(16'h1800, 1);
        send(16'h0800, persistence_filter[c] - 1);
        chk("flag", lightIntFlag, 0);
      end
      send((c == 0) ? 16'h1800 : 16'h3000, 1);
      chk("flag", lightIntFlag, 1);
      chk("pin", intPinOe, lightIntEnable);
      atic_host_inst.clrFlag();
    end
    for (int l = 0; l < 2; l++)
    begin
      waitPeriodValue = 8'($urandom_range(3));
      atic_host_inst.wrCfg0(l[0]);
      rd(atic_pkg::ADDR_CONFIG_ZERO_WAIT, {5'h10, l[0], 2'h0});
      atic_host_inst.idle();
      waitStart = 1;
      @(posedge clk_sys);
      #1;
      waitStart = 0;
      n = 0;
      while (waitDone !== 1'b1 && n < 1000)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      r = 16'((waitPeriodValue + 1) * STEP * (l ? atic_pkg::LONG_WAIT_FACTOR : 1));
      chk("wait", 16'(n), r);
    end
    tally_and_finish();
  end
endmodule : test_atic_top
